// ==== dv/iod_top_test.sv ====
// Self-checking bench for the oscillator divider.
`timescale 1ns/100ps
module iod_top_test;
    logic clk_i = 0, rst_i = 1, en, cyc = 0, stb = 0, we = 0, ack, meas = 0;
    logic [31:0] adr = 0, dat = 0, rdo, rdat;
    logic [3:0] sel = 0;
    iod_pkg::iod_clk_s o;
    int cp, cs, cc, error_cnt = 0, comparisons = 0, cyc_n = 0;
    // Rows: write flag, offset, data, byte enables, expected read.
    logic tw[8] = '{0, 1, 0, 1, 0, 1, 0, 1};
    logic [7:0] ta[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h10,
        8'h00};
    logic [31:0] td[8] = '{0, 32'h4, 0, 32'h2, 0, 32'hFF, 0, 0};
    logic [3:0] ts[8] = '{4'hF, 4'h1, 4'hF, 4'h0, 4'hF, 4'hF, 4'hF, 4'h1};
    logic [31:0] te[8] = '{0, 0, 32'h4, 0, 32'h4, 0, 0, 0};
    int ce[3] = '{40, 240, 480};
    iod_top #(.DIV1_RATIO(16), .DIV2_RATIO(8)) dut (.clk_i(clk_i),
        .rst_i(rst_i), .user_clk_en_i(en), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_dat_o(rdo), .wb_ack_o(ack), .primary_divided_output_o(o.primary),
        .secondary_divided_output_o(o.secondary),
        .config_serial_clock_o(o.config_serial_clock));
    iod_user_model model (.clk_i(clk_i), .meas_i(meas), .clk_s_i(o),
        .user_clk_en_o(en), .cnt_p_o(cp), .cnt_s_o(cs), .cnt_c_o(cc));
    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; the run needs about 16000 cycles.
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 60000) begin
            error_cnt++;
            results();
        end
    end
    task results();
        $display("checks %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [31:0] near(input int v, input int e, int t);
        return {31'h0, (v >= e - t) && (v <= e + t)};
    endfunction : near
    // Classic cycle; the request stands until ack is seen at a rising
    // edge, and data is taken at that same edge; the hang guard ends a
    // wait that never finishes.
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= {24'h0, a};
        dat <= d;
        sel <= s;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rdat = rdo;
        cyc <= 0;
        stb <= 0;
        we <= 0;
    endtask : wb
    // Edge counts over 4000 cycles, that is 40 us.
    task win();
        @(posedge clk_i);
        meas <= 1;
        repeat (4000) @(posedge clk_i);
        meas <= 0;
        @(negedge clk_i);
    endtask : win
    ////////////////////////////////////////////////////////////////////////
    // Register rows, then rates per source and select, then a reset.
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 0;
        for (int i = 0; i < 8; i++) begin
            wb(tw[i], ta[i], td[i], ts[i]);
            if (!tw[i]) chk(rdat, te[i]);
        end
        for (int c = 0; c < 3; c++) begin
            wb(1, 8'h00, {29'h0, 2'(c), 1'b0}, 4'h1);
            win();
            chk(near(cc, ce[c], ce[c] / 10), 32'h1);
        end
        chk(near(cp, 30, 3), 32'h1);
        chk(near(cs, 60, 6), 32'h1);
        wb(1, 8'h00, 32'h1, 4'h1);
        win();
        chk(near(cp, 62, 1), 32'h1);
        chk(near(cs, 125, 1), 32'h1);
        @(posedge clk_i);
        rst_i <= 1;
        @(posedge clk_i);
        @(negedge clk_i);
        chk({29'h0, o}, 32'h0);
        @(posedge clk_i);
        rst_i <= 0;
        wb(0, 8'h00, 0, 4'hF);
        chk(rdat, 32'h0);
        wb(0, 8'h04, 0, 4'hF);
        chk(rdat, 32'h0);
        wb(0, 8'h08, 0, 4'hF);
        chk(near(rdat, 2, 1), 32'h1);
        results();
    end
endmodule : iod_top_test

// ==== dv/iod_user_model.sv ====
// Fabric-side model: makes a user clock and counts divider edges.
`timescale 1ns/100ps
module iod_user_model (
    input wire logic clk_i,
    input wire logic meas_i,
    input wire iod_pkg::iod_clk_s clk_s_i,
    output logic user_clk_en_o,
    output int cnt_p_o,
    output int cnt_s_o,
    output int cnt_c_o
);
    int n = 0;
    iod_pkg::iod_clk_s last_q;
    ////////////////////////////////////////////////////////////////////////
    // One user clock edge every other cycle, so ticks differ from osc.
    always_ff @(posedge clk_i) begin
        n <= n + 1;
    end
    assign user_clk_en_o = n[0];
    // Rising edges are counted only in the window, cleared outside it.
    always_ff @(posedge clk_i) begin
        last_q <= clk_s_i;
        if (!meas_i) begin
            cnt_p_o <= 0;
            cnt_s_o <= 0;
            cnt_c_o <= 0;
        end else begin
            cnt_p_o <= cnt_p_o + int'(clk_s_i.primary & ~last_q.primary);
            cnt_s_o <= cnt_s_o + int'(clk_s_i.secondary & ~last_q.secondary);
            cnt_c_o <= cnt_c_o + int'(clk_s_i.config_serial_clock & ~last_q.config_serial_clock);
        end
    end
endmodule : iod_user_model

// ==== hw/iod_pkg.sv ====
// Package with constants and register layout for the oscillator divider.
package iod_pkg;
    // Nominal internal oscillator rate in kHz.
    localparam int OSC_KHZ = 12000;
    // Host clock rate in kHz.
    localparam int CLK_KHZ = 100000;
    // Configuration clock choices in kHz.
    localparam int CONFIG_SERIAL_CLOCK_1_KHZ = 1000;
    localparam int CONFIG_SERIAL_CLOCK_6_KHZ = 6000;
    localparam int CONFIG_SERIAL_CLOCK_12_KHZ = 12000;
    // Register byte offsets.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_COUNT = 8'h08;
    // Control field positions.
    localparam int CTRL_SRC_BIT = 0;
    localparam int CTRL_CSEL_LO = 1;
    localparam int CTRL_CSEL_HI = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // Configuration clock select codes.
    localparam logic [1:0] CSEL_1MHZ = 2'h0;
    localparam logic [1:0] CSEL_6MHZ = 2'h1;
    localparam logic [1:0] CSEL_12MHZ = 2'h2;
    // Counter width gives a tap for the largest divide ratio of 65536.
    localparam int CNT_W = 17;
    // Output bundle of the divider.
    typedef struct packed {
        logic primary;
        logic secondary;
        logic config_serial_clock;
    } iod_clk_s;
endpackage : iod_pkg

// ==== hw/iod_top.sv ====
// Internal oscillator, configuration clock and fixed ratio divider.
//
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
module iod_top #(
    parameter int DIV1_RATIO = 4,
    parameter int DIV2_RATIO = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic user_clk_en_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic primary_divided_output_o,
    output logic secondary_divided_output_o,
    output logic config_serial_clock_o
);
    // Log2 of a power of two ratio.
    function automatic int lg2(int r);
        lg2 = 0;
        while ((1 << lg2) < r) lg2 = lg2 + 1;
    endfunction : lg2

    // Design time checks keep the ratios to the legal sets.  The secondary
    // set is not a plain geometric series (it jumps by eight after 128),
    // so the legal values are listed rather than generated.
    initial begin
        if (!(DIV1_RATIO inside {4, 16, 64, 256})) begin
            $error("primary ratio must be 4, 16, 64 or 256");
        end
        if (!(DIV2_RATIO inside {2, 8, 32, 128, 1024, 4096, 16384,
                                 65536})) begin
            $error("secondary ratio is not a legal value");
        end
        if (lg2(DIV2_RATIO) >= iod_pkg::CNT_W) begin
            $error("divider counter too narrow for the ratio");
        end
    end

    // A counter bit k toggles every 2**k source ticks, and a tick is half
    // a source period, so bit log2(ratio) has a period of ratio source
    // periods.
    localparam int TAP1 = lg2(DIV1_RATIO);
    localparam int TAP2 = lg2(DIV2_RATIO);
    // Phase accumulator step for the 12 MHz oscillator from 100 MHz.
    localparam logic [16:0] OSC_STEP =
        17'((iod_pkg::OSC_KHZ * 2 * 65536) / iod_pkg::CLK_KHZ);
    // Config clock half periods counted in oscillator ticks.  A tick is a
    // half period of the oscillator, so the count is OSC over CONFIG_SERIAL_CLOCK.
    localparam logic [4:0] HALF_1 =
        5'(iod_pkg::OSC_KHZ / iod_pkg::CONFIG_SERIAL_CLOCK_1_KHZ);
    localparam logic [4:0] HALF_6 =
        5'(iod_pkg::OSC_KHZ / iod_pkg::CONFIG_SERIAL_CLOCK_6_KHZ);
    localparam logic [4:0] HALF_12 =
        5'(iod_pkg::OSC_KHZ / iod_pkg::CONFIG_SERIAL_CLOCK_12_KHZ);

    ////////////////////////////////////////////////////////////////////////
    // Register file.
    logic [31:0] ctrl_q;
    logic [iod_pkg::CNT_W-1:0] cnt_q;
    logic acc_q;
    logic wb_hit;
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // Control write; source and config clock select live here.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= iod_pkg::CTRL_RESET;
        end else if (wb_hit && wb_we_i && wb_sel_i[0] &&
                     wb_adr_i[7:0] == iod_pkg::REG_CTRL) begin
            ctrl_q <= {29'h0, wb_dat_i[2:0]};
        end
    end

    // One cycle acknowledge, reads decoded at the same edge.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= 32'h0;
            if (wb_hit && !wb_we_i) begin
                unique case (wb_adr_i[7:0])
                    iod_pkg::REG_CTRL: wb_dat_o <= ctrl_q;
                    iod_pkg::REG_STATUS: wb_dat_o <= {29'h0,
                        config_serial_clock_o, secondary_divided_output_o,
                        primary_divided_output_o};
                    iod_pkg::REG_COUNT: wb_dat_o <= 32'(cnt_q);
                    default: wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Internal oscillator as a phase accumulator giving edge enables.
    logic [15:0] phase_q;
    logic osc_tick_q;
    logic [16:0] phase_sum;
    assign phase_sum = {1'b0, phase_q} + OSC_STEP;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_q <= 16'h0;
            osc_tick_q <= 1'b0;
        end else begin
            phase_q <= phase_sum[15:0];
            osc_tick_q <= phase_sum[16];
        end
    end

    // Source choice: bit set selects the user clock enable.
    logic src_tick;
    assign src_tick = ctrl_q[iod_pkg::CTRL_SRC_BIT] ? user_clk_en_i
                                                    : osc_tick_q;

    // Free-running counter; each edge tick advances it by one half cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            acc_q <= 1'b0;
        end else if (src_tick) begin
            cnt_q <= cnt_q + 1'b1;
            acc_q <= ~acc_q;
        end
    end

    // Outputs tap fixed counter bits, so ratios cannot change at run time.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            primary_divided_output_o <= 1'b0;
            secondary_divided_output_o <= 1'b0;
        end else begin
            primary_divided_output_o <= cnt_q[TAP1];
            secondary_divided_output_o <= cnt_q[TAP2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Config clock from oscillator ticks, which are half periods of 12 MHz.
    logic [4:0] cc_cnt_q;
    logic [4:0] cc_half;
    always_comb begin
        unique case (ctrl_q[iod_pkg::CTRL_CSEL_HI:iod_pkg::CTRL_CSEL_LO])
            iod_pkg::CSEL_6MHZ: cc_half = HALF_6 - 5'h1;
            iod_pkg::CSEL_12MHZ: cc_half = HALF_12 - 5'h1;
            default: cc_half = HALF_1 - 5'h1;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cc_cnt_q <= 5'h0;
            config_serial_clock_o <= 1'b0;
        end else if (osc_tick_q) begin
            if (cc_cnt_q >= cc_half) begin
                cc_cnt_q <= 5'h0;
                config_serial_clock_o <= ~config_serial_clock_o;
            end else begin
                cc_cnt_q <= cc_cnt_q + 5'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    a_counter_steps: assert property (@(posedge clk_i) disable iff (rst_i)
        src_tick |=> cnt_q == $past(cnt_q) + 1'b1)
        else $error("counter missed a source tick");
    a_counter_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        !src_tick |=> $stable(cnt_q))
        else $error("counter moved without a tick");
    a_primary_tap: assert property (@(posedge clk_i) disable iff (rst_i)
        primary_divided_output_o == $past(cnt_q[TAP1]))
        else $error("primary output off its tap");
    a_secondary_tap: assert property (@(posedge clk_i) disable iff (rst_i)
        secondary_divided_output_o == $past(cnt_q[TAP2]))
        else $error("secondary output off its tap");
    a_osc_gap: assert property (@(posedge clk_i) disable iff (rst_i)
        osc_tick_q |=> !osc_tick_q [*3])
        else $error("oscillator ticks too close");
    a_osc_live: assert property (@(posedge clk_i) disable iff (rst_i)
        osc_tick_q |-> ##[1:6] osc_tick_q)
        else $error("oscillator stalled");
    a_config_serial_clock_default: assert property (@(posedge clk_i)
        rst_i |=> ctrl_q[iod_pkg::CTRL_CSEL_HI:iod_pkg::CTRL_CSEL_LO] ==
            iod_pkg::CSEL_1MHZ)
        else $error("config clock not 1 MHz after reset");
    a_config_serial_clock_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !osc_tick_q |=> $stable(config_serial_clock_o))
        else $error("config clock moved off a tick");
    a_wb_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    ////////////////////////////////////////////////////////////////////////
    // Bus checks.  A request taken at one edge is answered at the next,
    // and nothing else may raise ack; a stray ack would end a master's
    // cycle early and hand it stale data.
    a_wb_ack_follows: assert property (@(posedge clk_i)
        disable iff (rst_i)
        wb_hit |=> wb_ack_o)
        else $error("request not acknowledged");

    // Ack only ever answers a request that was taken.
    a_wb_no_stray: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !wb_hit |=> !wb_ack_o)
        else $error("ack without a request");

    // Read data is zero outside the ack cycle, so a late sample is seen.
    a_wb_data_idle: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");

    // A write to REG_CTRL with the low lane enabled lands in the control register.
    a_ctrl_write: assert property (@(posedge clk_i)
        disable iff (rst_i)
        wb_hit && wb_we_i && wb_sel_i[0] &&
        wb_adr_i[7:0] == iod_pkg::REG_CTRL
        |=> ctrl_q[2:0] == $past(wb_dat_i[2:0]))
        else $error("control write lost");

    // Without the low lane the control register must not move.
    a_ctrl_no_sel: assert property (@(posedge clk_i)
        disable iff (rst_i)
        wb_hit && wb_we_i && !wb_sel_i[0] |=> $stable(ctrl_q))
        else $error("control changed without lane");

    // Only the three defined control bits can ever be set.
    a_ctrl_upper: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ctrl_q[31:3] == 29'h0)
        else $error("undefined control bits set");

    // Status reads return the output levels of the request edge.
    a_status_read: assert property (@(posedge clk_i)
        disable iff (rst_i)
        wb_hit && !wb_we_i && wb_adr_i[7:0] == iod_pkg::REG_STATUS
        |=> wb_dat_o[2:0] == $past({config_serial_clock_o,
            secondary_divided_output_o, primary_divided_output_o}))
        else $error("status read wrong");

    // Count reads return the counter of the request edge.
    a_count_read: assert property (@(posedge clk_i)
        disable iff (rst_i)
        wb_hit && !wb_we_i && wb_adr_i[7:0] == iod_pkg::REG_COUNT
        |=> wb_dat_o == 32'($past(cnt_q)))
        else $error("count read wrong");

    ////////////////////////////////////////////////////////////////////////
    // Divider checks.  The toggle flop tracks the source clock itself and
    // must agree with the counter's lowest bit, which catches a counter
    // that skips or doubles a tick.
    a_acc_parity: assert property (@(posedge clk_i)
        disable iff (rst_i)
        acc_q == cnt_q[0])
        else $error("counter parity lost");

    // After a reset every output sits low for the next cycle.
    a_reset_quiet: assert property (@(posedge clk_i)
        rst_i |=> !primary_divided_output_o &&
            !secondary_divided_output_o && !config_serial_clock_o)
        else $error("output high after reset");

    ////////////////////////////////////////////////////////////////////////
    // Config clock checks.  A tick that ends a half period must toggle
    // the clock; a shortened half period would push the rate over the
    // selected value.
    a_config_serial_clock_toggle: assert property (@(posedge clk_i)
        disable iff (rst_i)
        osc_tick_q && cc_cnt_q >= cc_half
        |=> config_serial_clock_o != $past(config_serial_clock_o))
        else $error("config clock missed a toggle");

    // The half period count never reaches the slowest half period.
    a_cc_bound: assert property (@(posedge clk_i)
        disable iff (rst_i)
        cc_cnt_q < HALF_1)
        else $error("config clock count out of range");
endmodule : iod_top
